/* rtl/ptm_pkg.sv */
// Package with register map, field layout, reset values, modes and helper functions of the periodic timer.
package ptm_pkg;

  // Counter and data widths.
  localparam int CNT_W  = 10;
  localparam int ADDR_W = 12;
  localparam int IRQ_W  = 2;

  // Register byte addresses on the APB bus.
  localparam logic [ADDR_W-1:0] OFS_CTRL0   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CTRL1   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_CMPA_LO = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CMPA_HI = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_CMPP_LO = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_CMPP_HI = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN  = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 12'h028;

  // Field positions in the first control register.
  localparam int C0_HOLD_BIT   = 7;
  localparam int C0_CLKSEL_LSB = 4;
  localparam int C0_ON_BIT     = 3;

  // Field positions in the second control register.
  localparam int C1_MODE_LSB   = 6;
  localparam int C1_PINF_LSB   = 4;
  localparam int C1_INIT_BIT   = 3;
  localparam int C1_INV_BIT    = 2;
  localparam int C1_CAPSRC_BIT = 1;
  localparam int C1_CLRSEL_BIT = 0;

  // Reset values.
  localparam logic [7:0]       CTRL0_RST = 8'h00;
  localparam logic [7:0]       CTRL1_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RST   = 10'h000;

  // Interrupt status bit positions.
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_P_BIT = 1;

  // Prescaler divide ratios.
  localparam int SYS_DIV    = 4;
  localparam int HS_DIV_LO  = 16;
  localparam int HS_DIV_HI  = 64;
  localparam int HS_PRE_W   = 6;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'b000,
    CLK_SYS      = 3'b001,
    CLK_HS_DIV16 = 3'b010,
    CLK_HS_DIV64 = 3'b011,
    CLK_TIMEBASE = 3'b100,
    CLK_HS       = 3'b101,
    CLK_EXT_RISE = 3'b110,
    CLK_EXT_FALL = 3'b111
  } clk_sel_t;

  typedef enum logic [1:0] {
    PINF_NONE = 2'b00,
    PINF_LOW  = 2'b01,
    PINF_HIGH = 2'b10,
    PINF_TOG  = 2'b11
  } pinf_t;

  // Rising edge of a registered level against its previous sample.
  function automatic logic rise_of(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Falling edge of a registered level against its previous sample.
  function automatic logic fall_of(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction

endpackage

/* rtl/tick_if.sv */
// Interface between the timer core and its count clock generator.
`timescale 1ns/1ps
interface tick_if;
  import ptm_pkg::*;

  logic     run;
  clk_sel_t sel;
  logic     tick;
  logic     ext_rise;
  logic     ext_fall;

  modport gen  (input run, input sel, output tick, output ext_rise, output ext_fall);
  modport user (output run, output sel, input tick, input ext_rise, input ext_fall);
endinterface

/* rtl/count_tick_gen.sv */
// Count clock generator: prescalers, clock source selection and external input edge detection.
`timescale 1ns/1ps
module count_tick_gen (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic high_speed_tick,
  input  wire logic timebase_tick,
  input  wire logic external_count_input,
  tick_if.gen       t
);
  import ptm_pkg::*;

  logic [1:0]          sys_pre_r;
  logic [HS_PRE_W-1:0] hs_pre_r;
  logic                ext_s1_r;
  logic                ext_s2_r;
  logic                ext_s3_r;
  wire                 hs_div16_hit;
  wire                 hs_div64_hit;
  wire                 sys_div4_hit;

  // External pin passes two flip-flops; the third keeps the old level for edge detection.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_input;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  assign t.ext_rise = rise_of(ext_s2_r, ext_s3_r);
  assign t.ext_fall = fall_of(ext_s2_r, ext_s3_r);

  // Prescalers stay cleared while the counter is stopped, which saves their toggling power.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_pre_r <= 2'b00;
      hs_pre_r  <= '0;
    end else if (!t.run) begin
      sys_pre_r <= 2'b00;
      hs_pre_r  <= '0;
    end else begin
      sys_pre_r <= sys_pre_r + 2'b01;
      if (high_speed_tick) begin
        hs_pre_r <= hs_pre_r + 6'h01;
      end
    end
  end

  assign sys_div4_hit = (sys_pre_r == 2'((SYS_DIV - 1)));
  assign hs_div16_hit = high_speed_tick && (hs_pre_r[3:0] == 4'((HS_DIV_LO - 1)));
  assign hs_div64_hit = high_speed_tick && (hs_pre_r == 6'((HS_DIV_HI - 1)));

  // One enabled edge per selected source event; the core gates it again with run.
  always_comb begin
    case (t.sel)
      CLK_SYS_DIV4: t.tick = sys_div4_hit;
      CLK_SYS:      t.tick = 1'b1;
      CLK_HS_DIV16: t.tick = hs_div16_hit;
      CLK_HS_DIV64: t.tick = hs_div64_hit;
      CLK_TIMEBASE: t.tick = timebase_tick;
      CLK_HS:       t.tick = high_speed_tick;
      CLK_EXT_RISE: t.tick = t.ext_rise;
      CLK_EXT_FALL: t.tick = t.ext_fall;
      default:      t.tick = 1'b0;
    endcase
  end
endmodule

/* rtl/irq_status.sv */
// Sticky interrupt status with enable mask and write-one-to-clear register.
`timescale 1ns/1ps
module irq_status #(
  parameter int W = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] event_set,
  input  wire logic         clear_wr,
  input  wire logic         enable_wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);
  logic [W-1:0] status_r;
  logic [W-1:0] enable_r;
  wire  [W-1:0] status_nxt;

  // A new event wins over a clear written in the same cycle.
  assign status_nxt = (status_r & ~(clear_wr ? wdata : '0)) | event_set;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_r <= '0;
      enable_r <= '0;
    end else begin
      status_r <= status_nxt;
      if (enable_wr) begin
        enable_r <= wdata;
      end
    end
  end

  assign status = status_r;
  assign enable = enable_r;
  assign irq    = |(status_r & enable_r);
endmodule

/* rtl/periodic_timer_10bit.sv */
// Top of the 10-bit periodic timer: APB registers, counter, comparators, capture and output pin control.
// How it works
// - Ten-bit up-counter advances on the software-selected internal clock or external input.
// - Comparators A and P compare the counter with compare-A and compare-P values.
// - Software cannot load the counter; only a counter_on rising edge or a clearing match clears it.
// - The selected clearing match (A, or P/overflow) clears the counter and sets its interrupt flag.
// - counter_hold freezes the counter; clearing it resumes counting from the held value.
// - clock_source_select picks sys/4, sys, hs/16, hs/64, timebase, hs, external edges.
// - Clearing counter_on stops counting, idles the prescalers, and keeps the counter value.
// - In compare output mode a counter_on rising edge restores the pin initial level.
// - operating_mode_select chooses compare output, capture or timer mode; the PWM/single pulse code acts as timer mode.
// - In timer/counter mode the output pin is not driven.
// - Counter reads through a read-only pair; compare values are read/write pairs.
// - The three low bits of the first control register always read zero.
// - One external count input pin and one driven timer pin.
// - clear_source_select set clears on A match, else on P match or overflow; capture mode always clears on P.
// - In compare output mode an A match leaves, lowers, raises or toggles the pin.
// - output_initial_level gives the compare output pin level before any match.
// - output_invert inverts the pin; it has no effect in timer/counter mode.
`timescale 1ns/1ps
module periodic_timer_10bit (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [ptm_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         high_speed_tick,
  input  wire logic                         timebase_tick,
  input  wire logic                         external_count_input,
  input  wire logic                         timer_io_pin_in,
  output logic                              timer_io_pin_out,
  output logic                              timer_io_pin_oe_n,
  output logic                              irq
);
  import ptm_pkg::*;

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // Software-visible control state.
  logic [7:0]       ctrl0_r;
  logic [7:0]       ctrl1_r;
  logic [CNT_W-1:0] cmp_a_r;
  logic [CNT_W-1:0] cmp_p_r;

  // Core state.
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             on_prev_r;
  logic             out_r;
  logic             out_nxt;
  logic [31:0]      prdata_r;
  logic [31:0]      rd_mux;

  // Timer pin input synchroniser and its edge history.
  logic             pin_s1_r;
  logic             pin_s2_r;
  logic             pin_s3_r;

  // Decoded fields.
  wire              counter_on;
  wire              counter_hold;
  clk_sel_t         clock_source_select;
  mode_t            operating_mode_select;
  pinf_t            pin_function_select;
  wire              output_initial_level;
  wire              output_invert;
  wire              capture_source_select;
  wire              clear_source_select;

  // Event and control wires.
  wire              on_rise;
  wire              active;
  wire              step;
  wire              a_hit;
  wire              p_hit;
  wire              p_at_top;
  wire              mode_cmp;
  wire              mode_cap;
  wire              clr_cnt;
  wire              cap_rise;
  wire              cap_fall;
  logic             capture;
  wire [IRQ_W-1:0]  events;
  wire [IRQ_W-1:0]  irq_st;
  wire [IRQ_W-1:0]  irq_en;

  // APB decode.
  wire              acc;
  wire              wr;
  wire              addr_ok;
  wire [7:0]        wbyte;

  tick_if t ();

  // Field decode from the control registers.
  assign counter_on            = ctrl0_r[C0_ON_BIT];
  assign counter_hold          = ctrl0_r[C0_HOLD_BIT];
  assign clock_source_select   = clk_sel_t'(ctrl0_r[C0_CLKSEL_LSB +: 3]);
  assign operating_mode_select = mode_t'(ctrl1_r[C1_MODE_LSB +: 2]);
  assign pin_function_select   = pinf_t'(ctrl1_r[C1_PINF_LSB +: 2]);
  assign output_initial_level  = ctrl1_r[C1_INIT_BIT];
  assign output_invert         = ctrl1_r[C1_INV_BIT];
  assign capture_source_select = ctrl1_r[C1_CAPSRC_BIT];
  assign clear_source_select   = ctrl1_r[C1_CLRSEL_BIT];

  assign mode_cmp = (operating_mode_select == MODE_CMP);
  assign mode_cap = (operating_mode_select == MODE_CAP);

  // The counter runs only while on and not held; the tick generator idles otherwise.
  assign active = counter_on && !counter_hold;
  assign t.run  = active;
  assign t.sel  = clock_source_select;

  count_tick_gen u_tick (
    .mclk                 (mclk),
    .rst                  (rst),
    .high_speed_tick      (high_speed_tick),
    .timebase_tick        (timebase_tick),
    .external_count_input (external_count_input),
    .t                    (t)
  );

  // Edge of counter_on against its previous value, seen in the same clock domain.
  assign on_rise = rise_of(counter_on, on_prev_r);
  assign step    = active && t.tick;

  // Comparators look at the current count on each enabled edge.
  // A zero compare-P value means the counter runs to its top and overflows.
  assign p_at_top = (cmp_p_r == '0);
  assign a_hit    = step && (cnt_r == cmp_a_r);
  assign p_hit    = step && (p_at_top ? (cnt_r == CNT_MAX) : (cnt_r == cmp_p_r));

  // Capture mode always clears on P; other modes follow clear_source_select.
  assign clr_cnt = mode_cap ? p_hit
                 : (clear_source_select ? a_hit : p_hit);

  // Counter next value; software has no load path at all.
  always_comb begin
    cnt_nxt = cnt_r;
    if (on_rise) begin
      cnt_nxt = '0;
    end else if (clr_cnt) begin
      cnt_nxt = '0;
    end else if (step) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // Timer pin sampled through two flip-flops before the capture edge logic sees it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= timer_io_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign cap_rise = capture_source_select ? t.ext_rise : rise_of(pin_s2_r, pin_s3_r);
  assign cap_fall = capture_source_select ? t.ext_fall : fall_of(pin_s2_r, pin_s3_r);

  // Capture edge selection reuses the pin function field; code 11 disables capture.
  always_comb begin
    case (pin_function_select)
      PINF_NONE: capture = cap_rise;
      PINF_LOW:  capture = cap_fall;
      PINF_HIGH: capture = cap_rise || cap_fall;
      PINF_TOG:  capture = 1'b0;
      default:   capture = 1'b0;
    endcase
    capture = capture && mode_cap && counter_on;
  end

  // A flag: A match outside capture mode, or a capture. P flag: P match unless A clears.
  assign events[IRQ_A_BIT] = (a_hit && !mode_cap) || capture;
  assign events[IRQ_P_BIT] = p_hit && (mode_cap || !clear_source_select);

  // Output level: initial level on enable, then the selected action on each A match.
  always_comb begin
    out_nxt = out_r;
    if (mode_cmp && on_rise) begin
      out_nxt = output_initial_level;
    end else if (mode_cmp && a_hit) begin
      case (pin_function_select)
        PINF_NONE: out_nxt = out_r;
        PINF_LOW:  out_nxt = 1'b0;
        PINF_HIGH: out_nxt = 1'b1;
        PINF_TOG:  out_nxt = ~out_r;
        default:   out_nxt = out_r;
      endcase
    end
  end

  // Core registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r     <= '0;
      on_prev_r <= 1'b0;
      out_r     <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      on_prev_r <= counter_on;
      out_r     <= out_nxt;
    end
  end

  // The pin is driven only in compare output mode; timer mode leaves it to other functions.
  // PWM and single pulse waveforms are not generated here, so that mode also releases the pin.
  assign timer_io_pin_oe_n = !mode_cmp;
  assign timer_io_pin_out  = out_r ^ (output_invert && mode_cmp);

  // APB slave: no wait states, error on unmapped addresses.
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && addr_ok;
  assign wbyte   = pwdata[7:0];
  assign pready  = 1'b1;
  assign pslverr = acc && !addr_ok;
  assign addr_ok = (paddr == OFS_CTRL0)   || (paddr == OFS_CTRL1)   ||
                   (paddr == OFS_CNT_LO)  || (paddr == OFS_CNT_HI)  ||
                   (paddr == OFS_CMPA_LO) || (paddr == OFS_CMPA_HI) ||
                   (paddr == OFS_CMPP_LO) || (paddr == OFS_CMPP_HI) ||
                   (paddr == OFS_IRQ_ST)  || (paddr == OFS_IRQ_EN)  ||
                   (paddr == OFS_IRQ_CLR);

  // Software register writes; the mode field is taken as written, even while running.
  // A capture in the same cycle as a compare-A write wins, so a measured value is never lost.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl0_r <= CTRL0_RST;
      ctrl1_r <= CTRL1_RST;
      cmp_a_r <= CMP_RST;
      cmp_p_r <= CMP_RST;
    end else begin
      if (wr && paddr == OFS_CTRL0) begin
        ctrl0_r <= {wbyte[7:3], 3'b000};
      end
      if (wr && paddr == OFS_CTRL1) begin
        ctrl1_r <= wbyte;
      end
      if (capture) begin
        cmp_a_r <= cnt_r;
      end else if (wr && paddr == OFS_CMPA_LO) begin
        cmp_a_r[7:0] <= wbyte;
      end else if (wr && paddr == OFS_CMPA_HI) begin
        cmp_a_r[CNT_W-1:8] <= wbyte[CNT_W-9:0];
      end
      if (wr && paddr == OFS_CMPP_LO) begin
        cmp_p_r[7:0] <= wbyte;
      end else if (wr && paddr == OFS_CMPP_HI) begin
        cmp_p_r[CNT_W-1:8] <= wbyte[CNT_W-9:0];
      end
    end
  end

  irq_status #(
    .W (IRQ_W)
  ) u_irq (
    .mclk      (mclk),
    .rst       (rst),
    .event_set (events),
    .clear_wr  (wr && paddr == OFS_IRQ_CLR),
    .enable_wr (wr && paddr == OFS_IRQ_EN),
    .wdata     (wbyte[IRQ_W-1:0]),
    .status    (irq_st),
    .enable    (irq_en),
    .irq       (irq)
  );

  // Read mux; unused upper bits read zero and the clear register reads zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL0:   rd_mux[7:0] = ctrl0_r;
      OFS_CTRL1:   rd_mux[7:0] = ctrl1_r;
      OFS_CNT_LO:  rd_mux[7:0] = cnt_r[7:0];
      OFS_CNT_HI:  rd_mux[CNT_W-9:0] = cnt_r[CNT_W-1:8];
      OFS_CMPA_LO: rd_mux[7:0] = cmp_a_r[7:0];
      OFS_CMPA_HI: rd_mux[CNT_W-9:0] = cmp_a_r[CNT_W-1:8];
      OFS_CMPP_LO: rd_mux[7:0] = cmp_p_r[7:0];
      OFS_CMPP_HI: rd_mux[CNT_W-9:0] = cmp_p_r[CNT_W-1:8];
      OFS_IRQ_ST:  rd_mux[IRQ_W-1:0] = irq_st;
      OFS_IRQ_EN:  rd_mux[IRQ_W-1:0] = irq_en;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup cycle so it stands registered through the access cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;
endmodule

/* verif/ptm_properties.sv */
// Port-level assertions for the periodic timer.
`timescale 1ns/1ps
module ptm_properties (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic [ptm_pkg::ADDR_W-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  input wire logic                       timer_io_pin_out,
  input wire logic                       timer_io_pin_oe_n,
  input wire logic                       irq
);
  import ptm_pkg::*;
  logic [1:0] mode_r;
  logic       on_r;
  logic       lvl_r;
  wire        wr = psel && penable && pwrite;
  wire        rd = psel && penable && !pwrite;
  wire        bad = paddr > OFS_IRQ_CLR || paddr[1:0] != 2'h0;
  // Shadow of the written fields; writes land at the access edge since there are no wait states.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= 2'h0;
      on_r <= 1'b0;
      lvl_r <= 1'b0;
    end else if (wr && paddr == OFS_CTRL1) begin
      mode_r <= pwdata[7:6];
      lvl_r <= pwdata[3] ^ pwdata[2];
    end else if (wr && paddr == OFS_CTRL0) begin
      on_r <= pwdata[3];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // The output flop settles one edge after the on bit, so the level is sampled two edges on.
  err_unmapped_a: assert property (psel && penable && bad |-> pslverr)
    else $error("no error on unmapped access");
  err_access_a: assert property (pslverr |-> psel && penable && bad)
    else $error("stray bus error");
  c0_low_zero_a: assert property (rd && paddr == OFS_CTRL0 |-> prdata[2:0] == 3'h0)
    else $error("ctrl0 low bits read nonzero");
  cnt_hi_a: assert property (rd && paddr == OFS_CNT_HI |-> prdata[31:2] == 30'h0)
    else $error("counter high bits too wide");
  tmr_no_drive_a: assert property (mode_r == 2'h3 |-> timer_io_pin_oe_n)
    else $error("pin driven in timer mode");
  cmp_drive_a: assert property (mode_r == 2'h0 |-> !timer_io_pin_oe_n)
    else $error("pin not driven in compare mode");
  restart_lvl_a: assert property (wr && paddr == OFS_CTRL0 && pwdata[3] && !on_r && mode_r == 2'h0
    |-> ##2 timer_io_pin_out == lvl_r) else $error("pin not at initial level");
  irq_mask_a: assert property (wr && paddr == OFS_IRQ_EN && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("irq with all enables off");
  irq_c: cover property ($rose(irq));
  err_c: cover property (pslverr);
  restart_c: cover property (wr && paddr == OFS_CTRL0 && pwdata[3] && !on_r);
endmodule

/* verif/ptm_pin_model.sv */
// Board side: a pulse source on the count input and a driver on the shared timer pin.
`timescale 1ns/1ps
module ptm_pin_model (
  input  wire logic mclk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      ext_in,
  output logic      pin_in
);
  logic drv = 1'b0;
  initial ext_in = 1'b0;
  // The wire shows the device level while it drives, else the board level.
  assign pin_in = pin_oe_n ? drv : pin_out;
  // Edges are slow against mclk so the input synchroniser cannot miss one.
  task automatic pulse_ext(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      ext_in <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_in <= 1'b0;
    end
  endtask
  task automatic pulse_pin();
    @(posedge mclk);
    drv <= 1'b1;
    repeat (4) @(posedge mclk);
    drv <= 1'b0;
  endtask
endmodule

/* verif/periodic_timer_10bit_tb_top.sv */
// Self-checking testbench for the periodic timer.
`timescale 1ns/1ps
module periodic_timer_10bit_tb_top;
  import ptm_pkg::*;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = '0;
  logic              src_tick = 1'b0;
  logic [31:0]       prdata;
  logic              pready, pslverr, ext_in, pin_in, pin_out, pin_oe_n, irq;
  int                bad_count = 0;
  int                samples_checked = 0;
  always #2 mclk = ~mclk;
  periodic_timer_10bit dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_speed_tick(src_tick), .timebase_tick(src_tick), .external_count_input(ext_in), .timer_io_pin_in(pin_in),
    .timer_io_pin_out(pin_out), .timer_io_pin_oe_n(pin_oe_n), .irq(irq));
  ptm_pin_model pm (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_in(ext_in), .pin_in(pin_in));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(what, q, exp);
  endtask
  // Outputs are sampled 1 ns after the edge so that edge's updates have landed.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_irq();
    int n = 0;
    while (irq !== 1'b1 && n < 6000) begin
      @(posedge mclk);
      n++;
    end
    tick(2);
    chk("irq", 32'(irq), 32'h1);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd_chk("ctrl1", OFS_CTRL1, 32'h0);
    chk("oe_n", 32'(pin_oe_n), 32'h0);
    rd_chk("cmp a", OFS_CMPA_LO, 32'h0);
    wr(OFS_CTRL0, 8'hF7);
    rd_chk("ctrl0", OFS_CTRL0, 32'hF0);
    wr(OFS_CNT_LO, 8'hFF);
    rd_chk("cnt load", OFS_CNT_LO, 32'h0);
    wr(OFS_CTRL0, 8'h00);
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk("slverr", 32'(e), 32'h1);
    chk("bad rd", q, 32'h0);
  endtask
  // Timer mode, clear on P; flags, masking, hold, off and restart.
  task automatic t_period();
    logic [31:0] c;
    wr(OFS_CTRL1, 8'hC0);
    wr(OFS_CMPP_LO, 8'h05);
    wr(OFS_CMPA_LO, 8'h03);
    wr(OFS_IRQ_EN, 8'h02);
    wr(OFS_CTRL0, 8'h18);
    wait_irq();
    rd_chk("flags", OFS_IRQ_ST, 32'h3);
    wr(OFS_IRQ_EN, 8'h00);
    tick(1);
    chk("masked", 32'(irq), 32'h0);
    wr(OFS_CTRL0, 8'h98);
    rd(OFS_CNT_LO, c);
    chk("range", 32'(c <= 32'h5), 32'h1);
    tick(10);
    rd_chk("held", OFS_CNT_LO, c);
    wr(OFS_CTRL0, 8'h10);
    tick(10);
    rd_chk("off", OFS_CNT_LO, c);
    wr(OFS_IRQ_CLR, 8'h03);
    rd_chk("cleared", OFS_IRQ_ST, 32'h0);
    wr(OFS_CTRL0, 8'h98);
    rd_chk("restart", OFS_CNT_LO, 32'h0);
    wr(OFS_CTRL0, 8'h00);
  endtask
  // Compare output mode: every pin function, then invert and restart.
  task automatic t_compare();
    logic init;
    wr(OFS_CMPP_LO, 8'h00);
    wr(OFS_CMPA_LO, 8'h08);
    wr(OFS_IRQ_EN, 8'h01);
    for (int p = 0; p < 4; p++) begin
      init = (p != 2);
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_IRQ_CLR, 8'h03);
      wr(OFS_CTRL1, {2'b00, 2'(p), init, 3'b000});
      wr(OFS_CTRL0, 8'h08);
      tick(2);
      chk("init", 32'(pin_out), 32'(init));
      wait_irq();
      chk("match", 32'(pin_out), 32'(p == 0 || p == 2));
    end
    wr(OFS_CTRL1, 8'h3C);
    tick(1);
    chk("invert", 32'(pin_out), 32'h1);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL0, 8'h08);
    tick(2);
    chk("reinit", 32'(pin_out), 32'h0);
    wr(OFS_CTRL0, 8'h00);
  endtask
  // Divided, timebase, high-speed and both external edge sources; mode changed only while off.
  task automatic t_ext();
    wr(OFS_CTRL1, 8'hC0);
    tick(1);
    chk("oe_n tmr", 32'(pin_oe_n), 32'h1);
    for (int s = 2; s < 8; s++) begin
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL0, {1'b0, 3'(s), 4'h8});
      tick(2);
      if (s > 5) begin
        pm.pulse_ext(3);
      end else begin
        repeat (64) begin
          @(posedge mclk) src_tick <= 1'b1;
          @(posedge mclk) src_tick <= 1'b0;
        end
      end
      tick(8);
      rd_chk("clk src", OFS_CNT_LO, (s > 5) ? 32'h3 : (s == 2) ? 32'h4 : (s == 3) ? 32'h1 : 32'h40);
    end
    wr(OFS_CTRL0, 8'h00);
  endtask
  // Capture mode: a pin edge copies the held counter into compare A.
  task automatic t_capture();
    logic [31:0] c;
    wr(OFS_CTRL1, 8'h40);
    wr(OFS_IRQ_CLR, 8'h03);
    wr(OFS_CTRL0, 8'h18);
    tick(20);
    wr(OFS_CTRL0, 8'h98);
    rd(OFS_CNT_LO, c);
    pm.pulse_pin();
    tick(6);
    rd_chk("capture", OFS_CMPA_LO, c);
    rd_chk("cap flag", OFS_IRQ_ST, 32'h1);
  endtask
  task automatic results();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence after a 5-cycle reset.
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_period();
    t_compare();
    t_ext();
    t_capture();
    results();
  end
  // Watchdog well beyond the roughly one thousand cycles the tests need.
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    results();
  end
endmodule
bind periodic_timer_10bit ptm_properties chk_i (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .timer_io_pin_out(timer_io_pin_out), .timer_io_pin_oe_n(timer_io_pin_oe_n), .irq(irq));
